// *** inc/shp_pkg.sv ***
package shp_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int DATA_W = 16;
   localparam int ADDR_W = 14;
   localparam int MEM_WORDS = 16384;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 40;
   localparam int WAKE_US = 600;
   localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
   // Last wait count: the access is held ACK_DLY+1 wait cycles before the acknowledge stage
   localparam logic [1:0] ACK_DLY = 2'h2;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;

   typedef enum {
      SHP_IDLE,
      SHP_WAIT,
      SHP_ACK,
      SHP_DONE
   } shp_state_t;

   // Host pin inputs bundled together
   typedef struct packed {
      logic              cs_n;
      logic              strobe_or_read_n;
      logic              rw_or_write_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } shp_pins_t;

endpackage

// *** test/shp_host_model.sv ***
`timescale 1ns/1ps
module shp_host_model (
   // Clock and style
   input wire logic clk,
   input wire logic bus_style_sel,
   // Pins to and from the port
   output logic cs_n,
   output logic strobe_or_read_n,
   output logic rw_or_write_n,
   output logic [13:0] host_addr_lines,
   output logic [15:0] host_bus_lines_in,
   input wire logic [15:0] host_bus_lines_out,
   input wire logic host_bus_lines_oe_n,
   input wire logic xfer_ack_out,
   input wire logic xfer_ack_oe_n
);
   logic hdrv = 0;
   logic [15:0] wd = 0, prev = 0;
   wire ack = xfer_ack_oe_n ? bus_style_sel : xfer_ack_out;
   wire done = bus_style_sel ? !ack : ack;
   // Released bus shows a moving pattern, not the last value
   assign host_bus_lines_in = hdrv ? wd : (host_bus_lines_oe_n ? ~prev : host_bus_lines_out);
   always @(posedge clk) prev <= host_bus_lines_in;
   initial begin
      cs_n = 1;
      strobe_or_read_n = 1;
      rw_or_write_n = 1;
      host_addr_lines = 0;
   end
   task automatic xfer(input logic en, wr, input logic [13:0] a, input logic [15:0] d,
                       input int stop, output logic [15:0] q, output logic ok);
      int n;
      n = 0;
      @(posedge clk);
      cs_n <= !en;
      strobe_or_read_n <= bus_style_sel ? 1'b0 : wr;
      rw_or_write_n <= !wr;
      host_addr_lines <= a;
      wd <= d;
      hdrv <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (!done && n != stop);
      ok = done;
      q = host_bus_lines_in;
      cs_n <= 1;
      strobe_or_read_n <= 1;
      rw_or_write_n <= 1;
      hdrv <= 0;
      @(posedge clk);
   endtask
endmodule

// *** test/shp_host_port_assertions.sv ***
`timescale 1ns/1ps
module shp_host_port_assertions #(
   parameter int WAKE_CYC = shp_pkg::WAKE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Host pins
   input wire logic bus_style_sel,
   input wire logic cs_n,
   input wire logic strobe_or_read_n,
   input wire logic rw_or_write_n,
   input wire logic host_bus_lines_oe_n,
   input wire logic xfer_ack_out,
   input wire logic xfer_ack_oe_n,
   input wire logic pll_status,
   input wire logic irq_n_oe_n
);
   logic req;
   logic rd;
   logic ack_on;
   assign req = !cs_n && (bus_style_sel ? !strobe_or_read_n
                                        : !(strobe_or_read_n && rw_or_write_n));
   assign rd = bus_style_sel ? rw_or_write_n : !strobe_or_read_n;
   // Ack sense flips with the style
   assign ack_on = bus_style_sel ? !xfer_ack_out : xfer_ack_out;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_start;
      !req ##1 req;
   endsequence
   sequence s_sep_rise;
      !bus_style_sel && req && $rose(xfer_ack_out);
   endsequence
   a_ack_given: assert property (s_start ##1 req[*7] |-> ack_on)
      else $error("ack late");
   a_ack_early: assert property (s_start ##1 req[*2] |-> !ack_on)
      else $error("ack early");
   a_ack_held: assert property (ack_on && req |=> ack_on)
      else $error("ack dropped");
   a_ack_release: assert property (ack_on && !req |=> !ack_on)
      else $error("ack stuck");
   a_read_drive: assert property (req && rd && ack_on |-> !host_bus_lines_oe_n)
      else $error("no rd");
   a_write_quiet: assert property (!cs_n && !rd |-> host_bus_lines_oe_n)
      else $error("drive");
   a_cs_float: assert property (cs_n |-> host_bus_lines_oe_n && xfer_ack_oe_n)
      else $error("float");
   a_irq_set: assert property ($changed(pll_status) |-> ##[1:2] !irq_n_oe_n)
      else $error("irq");
   // completion edge seen on a driven pin
   a_rise_driven: assert property (s_sep_rise |-> !xfer_ack_oe_n)
      else $error("ack rise unseen");
endmodule
bind shp_host_port shp_host_port_assertions #(.WAKE_CYC(WAKE_CYC)) u_chk (
   .clk                 (clk),
   .sys_rst             (sys_rst),
   .bus_style_sel       (bus_style_sel),
   .cs_n                (cs_n),
   .strobe_or_read_n    (strobe_or_read_n),
   .rw_or_write_n       (rw_or_write_n),
   .host_bus_lines_oe_n (host_bus_lines_oe_n),
   .xfer_ack_out        (xfer_ack_out),
   .xfer_ack_oe_n       (xfer_ack_oe_n),
   .pll_status          (pll_status),
   .irq_n_oe_n          (irq_n_oe_n)
);

// *** test/tb_switch_host_bus_port.sv ***
`timescale 1ns/1ps
module tb_switch_host_bus_port;
   logic clk = 0, sys_rst = 1, bus_style_sel = 1, pll_status = 0;
   logic cs_n, strobe_or_read_n, rw_or_write_n, host_bus_lines_oe_n, xfer_ack_out;
   logic xfer_ack_oe_n, irq_n_out, irq_n_oe_n, irq_enable_dummy_ready, ok;
   logic [13:0] host_addr_lines;
   logic [15:0] host_bus_lines_in, host_bus_lines_out, q;
   int errors = 0, n_tests = 0, cyc = 0;
   // Short wake window keeps the run brief
   localparam int WAKE_SIM = 20;
   always #12.5 clk = ~clk;
   shp_host_port #(.WAKE_CYC(WAKE_SIM)) dut (
      .clk                    (clk),
      .sys_rst                (sys_rst),
      .bus_style_sel          (bus_style_sel),
      .cs_n                   (cs_n),
      .strobe_or_read_n       (strobe_or_read_n),
      .rw_or_write_n          (rw_or_write_n),
      .host_addr_lines        (host_addr_lines),
      .host_bus_lines_in      (host_bus_lines_in),
      .host_bus_lines_out     (host_bus_lines_out),
      .host_bus_lines_oe_n    (host_bus_lines_oe_n),
      .xfer_ack_out           (xfer_ack_out),
      .xfer_ack_oe_n          (xfer_ack_oe_n),
      .pll_status             (pll_status),
      .irq_n_out              (irq_n_out),
      .irq_n_oe_n             (irq_n_oe_n),
      .irq_enable_dummy_ready (irq_enable_dummy_ready)
   );
   shp_host_model host (
      .clk                 (clk),
      .bus_style_sel       (bus_style_sel),
      .cs_n                (cs_n),
      .strobe_or_read_n    (strobe_or_read_n),
      .rw_or_write_n       (rw_or_write_n),
      .host_addr_lines     (host_addr_lines),
      .host_bus_lines_in   (host_bus_lines_in),
      .host_bus_lines_out  (host_bus_lines_out),
      .host_bus_lines_oe_n (host_bus_lines_oe_n),
      .xfer_ack_out        (xfer_ack_out),
      .xfer_ack_oe_n       (xfer_ack_oe_n)
   );
   task automatic chk(input logic [15:0] g, e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tally_and_finish;
      if (errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         tally_and_finish();
      end
   end
   // Writes to both address ends, then reads back
   task automatic t_rw(input logic s);
      logic [13:0] a[3] = '{14'h0000, 14'h3fff, 14'h1555};
      bus_style_sel <= s;
      foreach (a[i]) host.xfer(1, 1, a[i], {s, a[i], 1'b1}, 50, q, ok);
      foreach (a[i]) begin
         host.xfer(1, 0, a[i], 16'h0000, 50, q, ok);
         chk({15'h0000, ok}, 16'h0001);
         chk(q, {s, a[i], 1'b1});
      end
   endtask
   // Dropped strobe and idle chip select leave memory alone
   task automatic t_refuse(input logic s);
      bus_style_sel <= s;
      host.xfer(1, 1, 14'h0005, 16'h1234, 50, q, ok);
      host.xfer(1, 1, 14'h0005, 16'hffff, 2, q, ok);
      chk({15'h0000, ok}, 16'h0000);
      host.xfer(0, 1, 14'h0005, 16'hffff, 8, q, ok);
      chk({15'h0000, ok}, 16'h0000);
      host.xfer(1, 0, 14'h0005, 16'h0000, 50, q, ok);
      chk(q, 16'h1234);
   endtask
   task automatic t_irq;
      pll_status <= 1;
      repeat (3) @(posedge clk);
      chk({15'h0000, irq_n_oe_n}, 16'h0000);
      chk({15'h0000, irq_n_out}, 16'h0000);
      host.xfer(1, 0, 14'h0000, 16'h0000, 50, q, ok);
      chk({15'h0000, irq_n_oe_n}, 16'h0001);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      repeat (WAKE_SIM) begin
         chk({15'h0000, irq_enable_dummy_ready}, 16'h0000);
         @(posedge clk);
      end
      chk({15'h0000, irq_enable_dummy_ready}, 16'h0001);
      t_rw(1);
      t_rw(0);
      t_refuse(1);
      t_refuse(0);
      t_irq();
      tally_and_finish();
   end
endmodule

// *** verilog/shp_host_port.sv ***
// Notes on behaviour
// RULE_01 - Low chip select enables the port; high means the port is ignored.
// RULE_02 - Strobe style: direction line high reads, low writes.
// RULE_03 - Strobe style: access happens only while strobe and chip select are low.
// RULE_04 - Separate style: write strobe low captures the write data.
// RULE_05 - Separate style: read strobe low returns the addressed data.
// RULE_06 - Strobe style: acknowledge driven low when the transfer is complete.
// RULE_07 - Separate style: acknowledge rising edge marks the transfer complete.
// RULE_08 - Bidirectional 16-bit data: driven on reads, sampled on writes.
// RULE_09 - Full 14-bit address decoded on every access.
// RULE_10 - Style select high picks strobe style, low picks separate strobes.
// RULE_11 - Active-low interrupt output asserted when loop status changes.
// RULE_12 - Host waits 600 us after reset before the first access.
// RULE_13 - Data bus and acknowledge float while chip select is inactive.

`timescale 1ns/1ps

module shp_host_port #(
   parameter int WAKE_CYC = shp_pkg::WAKE_CYC
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   // Host control
   input  wire logic                       bus_style_sel,
   input  wire logic                       cs_n,
   input  wire logic                       strobe_or_read_n,
   input  wire logic                       rw_or_write_n,
   input  wire logic [shp_pkg::ADDR_W-1:0] host_addr_lines,
   // Host data lines
   input  wire logic [shp_pkg::DATA_W-1:0] host_bus_lines_in,
   output logic      [shp_pkg::DATA_W-1:0] host_bus_lines_out,
   output logic                            host_bus_lines_oe_n,
   // Acknowledge
   output logic                            xfer_ack_out,
   output logic                            xfer_ack_oe_n,
   // Interrupt
   input  wire logic                       pll_status,
   output logic                            irq_n_out,
   output logic                            irq_n_oe_n,
   output logic                            irq_enable_dummy_ready
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      shp_pkg::shp_state_t         st;
      logic                        is_rd;
      logic [1:0]                  dly;
      logic                        ack;
      logic [shp_pkg::DATA_W-1:0]  rdata;
      logic                        pll_prev;
      logic                        irq;
      logic [31:0]                 wake;
   } shp_regs_t;

   shp_regs_t state_ff;
   shp_regs_t nxt_state;

   shp_pkg::shp_pins_t pins;
   logic                       mem_wr;
   logic [shp_pkg::DATA_W-1:0] mem_rdata;
   logic                       req_on;
   logic                       req_rd;
   logic                       style_strobe;

   // ****************************************
   // Helpers
   // ****************************************
   // Pin level of the acknowledge for each handshake style
   function automatic logic ack_pin_level(
      input logic style,
      input logic done
   );
      // RULE_06 strobe style: low when complete
      // RULE_07 separate style: rises when complete
      return style ? !done : done;
   endfunction

   // Countdown that rests at zero rather than wrapping
   function automatic logic [31:0] count_down(
      input logic [31:0] cnt
   );
      logic [31:0] res;
      res = cnt;
      if (cnt != 32'h0000_0000) begin
         res = cnt - 32'h0000_0001;
      end
      return res;
   endfunction

   // One driver for the whole pin bundle
   assign pins = '{
      cs_n:             cs_n,
      strobe_or_read_n: strobe_or_read_n,
      rw_or_write_n:    rw_or_write_n,
      addr:             host_addr_lines,
      wdata:            host_bus_lines_in
   };

   // ****************************************
   // Request decode
   // ****************************************
   always_comb begin
      // RULE_10 style select
      style_strobe = bus_style_sel;
      if (style_strobe) begin
         // RULE_01 RULE_03 strobe with select
         req_on = !pins.cs_n && !pins.strobe_or_read_n;
         // RULE_02 direction line
         req_rd = pins.rw_or_write_n;
      end else begin
         // RULE_04 RULE_05 separate strobes
         req_on = !pins.cs_n && (!pins.strobe_or_read_n || !pins.rw_or_write_n);
         req_rd = !pins.strobe_or_read_n;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      nxt_state = state_ff;
      mem_wr    = 1'b0;
      nxt_state.pll_prev = pll_status;
      // RULE_11 loop status change
      if (pll_status != state_ff.pll_prev) begin
         nxt_state.irq = 1'b1;
      end
      // Readiness count only; it never blocks an access
      nxt_state.wake = count_down(state_ff.wake);
      case (state_ff.st)
         shp_pkg::SHP_IDLE: begin
            nxt_state.ack = 1'b0;
            if (req_on) begin
               nxt_state.is_rd = req_rd;
               nxt_state.dly   = 2'h0;
               nxt_state.st    = shp_pkg::SHP_WAIT;
            end
         end
         shp_pkg::SHP_WAIT: begin
            // Abort if the host drops the access early
            // Nothing is written before the last wait cycle, so memory stays clean
            if (!req_on) begin
               nxt_state.st = shp_pkg::SHP_IDLE;
            end else if (state_ff.dly == shp_pkg::ACK_DLY) begin
               // RULE_04 RULE_09 full-address write
               mem_wr = !state_ff.is_rd;
               // RULE_05 capture read word
               nxt_state.rdata = mem_rdata;
               nxt_state.st    = shp_pkg::SHP_ACK;
            end else begin
               nxt_state.dly = state_ff.dly + 2'h1;
            end
         end
         shp_pkg::SHP_ACK: begin
            nxt_state.ack = 1'b1;
            nxt_state.st  = shp_pkg::SHP_DONE;
         end
         shp_pkg::SHP_DONE: begin
            // Hold acknowledge until the host ends the cycle
            // A slow host may hold this state as long as it likes
            if (!req_on) begin
               nxt_state.ack = 1'b0;
               nxt_state.st  = shp_pkg::SHP_IDLE;
            end
         end
         default: begin
            nxt_state.st = shp_pkg::SHP_IDLE;
         end
      endcase
      // Interrupt cleared by any completed access; a new change wins
      // Keeping the set in that cycle means no status event is lost
      if (state_ff.st == shp_pkg::SHP_ACK && pll_status == state_ff.pll_prev) begin
         nxt_state.irq = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff.st       <= shp_pkg::SHP_IDLE;
         state_ff.is_rd    <= 1'b0;
         state_ff.dly      <= 2'h0;
         state_ff.ack      <= 1'b0;
         state_ff.rdata    <= shp_pkg::DATA_RST;
         state_ff.pll_prev <= 1'b0;
         state_ff.irq      <= 1'b0;
         // RULE_12 wake-up window
         state_ff.wake     <= WAKE_CYC[31:0];
      end else begin
         state_ff <= nxt_state;
      end
   end

   // RULE_09 all address bits reach the memory
   shp_mem u_mem (
      .clk      (clk),
      .wr_en    (mem_wr),
      .addr     (pins.addr),
      .wdata    (pins.wdata),
      .rdata_ff (mem_rdata)
   );

   // ****************************************
   // Pin drive
   // ****************************************
   // RULE_08 drive only on reads
   // Word was frozen at capture, so the bus never changes mid-read
   assign host_bus_lines_out  = state_ff.rdata;
   // RULE_13 float when not selected
   // Drive starts only in DONE, never while a slow host may still drive
   assign host_bus_lines_oe_n = !(!cs_n && state_ff.is_rd && state_ff.st == shp_pkg::SHP_DONE);
   // RULE_06 RULE_07 acknowledge polarity per style
   assign xfer_ack_out  = ack_pin_level(bus_style_sel, state_ff.ack);
   // RULE_13 acknowledge floats without select
   // Board pull sets the idle level while floating
   assign xfer_ack_oe_n = cs_n;
   // RULE_11 open drain, low only while the event is pending
   // The board pull-up gives the released level
   assign irq_n_out  = 1'b0;
   assign irq_n_oe_n = !state_ff.irq;
   // Low until the wake window has elapsed
   // Advisory only: the port does not lock out an early host
   assign irq_enable_dummy_ready = (state_ff.wake == 32'h0000_0000);

endmodule

// *** verilog/shp_mem.sv ***
`timescale 1ns/1ps

module shp_mem (
   // Clock
   input  wire logic                      clk,
   // Access
   input  wire logic                      wr_en,
   input  wire logic [shp_pkg::ADDR_W-1:0] addr,
   input  wire logic [shp_pkg::DATA_W-1:0] wdata,
   output logic      [shp_pkg::DATA_W-1:0] rdata_ff
);

   logic [shp_pkg::DATA_W-1:0] mem [shp_pkg::MEM_WORDS];

   // Registered read, write-first is not needed: reads and writes never overlap
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
      rdata_ff <= mem[addr];
   end

endmodule
